// *** design/vac_regs.svh ***
// constants for the valve actuator command logic
`ifndef VAC_REGS_SVH
`define VAC_REGS_SVH

// command word bit positions
`define VAC_CMD_STOP     0
`define VAC_CMD_CLOSE    1
`define VAC_CMD_OPEN     2
`define VAC_CMD_ESD      3
`define VAC_CMD_POS      4
`define VAC_CMD_PSTROKE  5
`define VAC_CMD_USED     6
`define VAC_CMD_POS_WORD 16'h0010

// position demand scale, 0.1 % per count
`define VAC_POS_ZERO     16'h0000
`define VAC_POS_FULL     16'h03E8

// relay word
`define VAC_RELAY_BITS   4
`define VAC_RELAY_RST    4'h0

// emergency action codes
`define VAC_ESD_CLOSE    2'h0
`define VAC_ESD_OPEN     2'h1
`define VAC_ESD_STAY     2'h2

// status flag positions
`define VAC_ST_OPEN      0
`define VAC_ST_CLOSED    1
`define VAC_ST_MOVING    2
`define VAC_ST_POSMODE   3
`define VAC_ST_REMOTE    4
`define VAC_ST_ESD       5
`define VAC_ST_BLOCKED   6

// cyclic word counts
`define VAC_IN_WORDS     7
`define VAC_OUT_WORDS    4

`endif

// *** design/vac_pkg.sv ***
// types shared by the valve actuator command logic
package vac_pkg;

  // motion states, gray order idle-open-position-close
  typedef enum logic [1:0] {
    VAC_IDLE     = 2'b00,
    VAC_OPENING  = 2'b01,
    VAC_POSITION = 2'b11,
    VAC_CLOSING  = 2'b10
  } vac_state_t;

  // cyclic output words from the master
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] demand;
    logic [15:0] relay;
  } vac_out_words_t;

  // card configuration
  typedef struct packed {
    logic       inhibit_en;
    logic [1:0] esd_action;
    logic       open_on_torque;
    logic       close_on_torque;
    logic       limited_range;
    logic       relay_fitted;
    logic [9:0] deadband;
    logic [2:0] in_words;
    logic [1:0] out_words;
  } vac_cfg_t;

  // field inputs, asynchronous to clk_sys
  typedef struct packed {
    logic remote;
    logic inhibit;
    logic hw_open;
    logic hw_close;
    logic ilk_open;
    logic ilk_close;
    logic alarm;
    logic lim_open;
    logic lim_close;
    logic torque_trip;
  } vac_pins_t;

  // cyclic input words to the master
  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] position;
  } vac_status_t;

endpackage : vac_pkg

// *** design/vac_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module vac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0]      s1_r;
  logic [W-1:0]      s2_r;
  logic [W-1:0]      s3_r;
  logic [W-1:0]      q_r;
  wire logic [W-1:0] q_nxt;

  // per bit: the output moves only when stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
  end

  // one process owns the whole chain; only stage two reads stage one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : vac_sync
`default_nettype wire

// *** design/vac_posn.sv ***
// deadband comparator for analogue positioning
`timescale 1ns/1ps
`default_nettype none
module vac_posn #(
  parameter int W  = 16,
  parameter int DW = 10
) (
  input  wire logic [W-1:0]  target,
  input  wire logic [W-1:0]  feedback,
  input  wire logic [DW-1:0] deadband,
  output var  logic          need_open,
  output var  logic          need_close
);

  logic [W:0] db_w;
  logic [W:0] hi_w;
  logic [W:0] lo_w;

  // widen by one bit so target plus band cannot wrap
  assign db_w       = {{(W+1-DW){1'b0}}, deadband};
  assign hi_w       = {1'b0, feedback} + db_w;
  assign lo_w       = {1'b0, target} + db_w;
  assign need_open  = {1'b0, target} > hi_w;
  assign need_close = {1'b0, feedback} > lo_w;

endmodule : vac_posn
`default_nettype wire

// *** design/vac_cmd.sv ***
// command interpreter for the valve actuator option card
//
// Contract
// - output words command, input words report status
// - exchanged word set follows card configuration
// - network moves actuator only in remote, except shutdown which needs no remote
// - enabled inhibit input blocks network commands
// - standing hardwired input blocks network commands
// - interlocks or alarms block network motion
// - interlocks stop opening or closing motion
// - open runs to limit, torque, new command (torque alone does not stop it here, only together with the open limit)
// - close runs to limit, torque, new command (torque alone does not stop it here, only together with the close limit)
// - stop command halts a running motor
// - shutdown drives to configured emergency action
// - open/closed status comes from limits only
// - demand spans full travel in 0.1% steps
// - positioning stops inside configured deadband
// - later open or close overrides positioning
// - positioner idles at target, tracks new writes
// - changed demand in positioning moves to it
// - new command bit ends positioning mode
// - 0% closes tight, 100% opens fully
// - fitted relay board gives four network relays
// - positioning accepted from network only
// - command word with several bits is ignored
// - demand encoded 0 to 1000 counts
// - relay word bits 0-3, one energises
`timescale 1ns/1ps
`default_nettype none
`include "vac_regs.svh"
module vac_cmd
  import vac_pkg::*;
#(
  parameter int PW = 16
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire vac_out_words_t out_words,
  input  wire logic           out_strobe,
  input  wire vac_cfg_t       cfg,
  input  wire vac_pins_t      pins_async,
  input  wire logic [PW-1:0]  pos_feedback,
  output var  logic           motor_open,
  output var  logic           motor_close,
  output var  logic [3:0]     relay_out,
  output var  vac_status_t    status,
  output var  logic [6:0]     in_exch_mask,
  output var  logic [3:0]     out_exch_mask,
  output var  logic           pos_mode,
  output var  logic           esd_active
);

  // one bit set, and nothing in the reserved field
  function automatic logic one_cmd(input logic [15:0] w);
    one_cmd = (w != 16'h0000) && ((w & (w - 16'h0001)) == 16'h0000)
              && (w[15:`VAC_CMD_USED] == '0);
  endfunction : one_cmd

  // contiguous low mask for a word count
  function automatic logic [6:0] low_mask(input logic [2:0] n);
    low_mask = 7'((8'h01 << n) - 8'h01);
  endfunction : low_mask

  vac_pins_t   p;
  vac_state_t  state_r;
  vac_state_t  state_nxt;
  vac_state_t  esd_state;
  logic        src_net_r;
  logic        src_net_nxt;
  logic        esd_r;
  logic        esd_nxt;
  logic        blocked_r;
  logic [15:0] last_cmd_r;
  logic [15:0] demand_r;
  logic [3:0]  relay_r;
  logic        mo_r;
  logic        mc_r;
  vac_status_t status_r;
  logic [6:0]  in_mask_r;
  logic [3:0]  out_mask_r;

  wire [15:0] cmd        = out_words.cmd;
  wire        hw_any     = p.hw_open | p.hw_close;
  wire        ilk_any    = p.ilk_open | p.ilk_close;
  wire        inhibited  = cfg.inhibit_en & p.inhibit;
  // word count plus one, cut to the four output words
  wire [6:0]  out_mask_w = low_mask({1'b0, cfg.out_words} + 3'h1);
  wire        esd_ok     = ~inhibited & ~hw_any & ~ilk_any & ~p.alarm;
  wire        net_ok     = p.remote & esd_ok;
  wire        new_word   = out_strobe & (cmd != last_cmd_r);
  wire        cmd_valid  = new_word & one_cmd(cmd);
  wire        is_esd     = cmd[`VAC_CMD_ESD];
  wire        cmd_ok     = is_esd ? esd_ok : net_ok;
  wire        accept     = cmd_valid & cmd_ok;
  wire        discard    = cmd_valid & ~cmd_ok;
  wire        demand_ok  = out_words.demand <= `VAC_POS_FULL;
  wire        open_done  = p.lim_open & (~cfg.open_on_torque | p.torque_trip);
  wire        close_done = p.lim_close
                         & (~cfg.close_on_torque | p.torque_trip);
  wire        hw_go_open  = p.remote & p.hw_open & ~p.hw_close & ~open_done;
  wire        hw_go_close = p.remote & p.hw_close & ~p.hw_open & ~close_done;
  wire        sp_close   = ~cfg.limited_range & (demand_r == `VAC_POS_ZERO);
  wire        sp_open    = ~cfg.limited_range & (demand_r == `VAC_POS_FULL);
  wire        need_open;
  wire        need_close;
  wire        pos_open;
  wire        pos_close;
  wire        want_open;
  wire        want_close;

  // field inputs cross into clk_sys
  vac_sync #(.W($bits(vac_pins_t))) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (pins_async),
    .q       (p)
  );

  // deadband comparison against the feedback word
  vac_posn #(.W(16), .DW(10)) u_posn (
    .target     (demand_r),
    .feedback   (pos_feedback),
    .deadband   (cfg.deadband),
    .need_open  (need_open),
    .need_close (need_close)
  );

  // end points override the servo unless range is limited
  assign pos_open  = sp_open  ? ~open_done  : (~sp_close & need_open);
  assign pos_close = sp_close ? ~close_done : (~sp_open & need_close);

  // motion request per state; interlocks and alarms veto at the motor
  assign want_open  = (state_r == VAC_OPENING)
                    | ((state_r == VAC_POSITION) & pos_open);
  assign want_close = (state_r == VAC_CLOSING)
                    | ((state_r == VAC_POSITION) & pos_close);

  // emergency action chosen by configuration
  assign esd_state = (cfg.esd_action == `VAC_ESD_CLOSE) ? VAC_CLOSING :
                     (cfg.esd_action == `VAC_ESD_OPEN)  ? VAC_OPENING :
                                                          VAC_IDLE;

  // next motion state; later assignments take priority
  always_comb begin
    state_nxt   = state_r;
    src_net_nxt = src_net_r;
    esd_nxt     = esd_r;
    if ((state_r == VAC_OPENING) && open_done) begin
      state_nxt = VAC_IDLE;
    end
    if ((state_r == VAC_CLOSING) && close_done) begin
      state_nxt = VAC_IDLE;
    end
    // network motion other than shutdown may not outlive its permission
    if (src_net_r && !esd_r && !net_ok) begin
      state_nxt = VAC_IDLE;
    end
    // a blocked or malformed word never reaches here
    if (accept) begin
      src_net_nxt = 1'b1;
      esd_nxt     = is_esd;
      if (cmd[`VAC_CMD_OPEN]) begin
        state_nxt = VAC_OPENING;
      end else if (cmd[`VAC_CMD_CLOSE]) begin
        state_nxt = VAC_CLOSING;
      end else if (cmd == `VAC_CMD_POS_WORD) begin
        state_nxt = VAC_POSITION;
      end else if (is_esd) begin
        state_nxt = esd_state;
      end else begin
        state_nxt = VAC_IDLE;
      end
    end
    // hardwired open or close wins over any positioning
    if (hw_go_open) begin
      state_nxt   = VAC_OPENING;
      src_net_nxt = 1'b0;
      esd_nxt     = 1'b0;
    end else if (hw_go_close) begin
      state_nxt   = VAC_CLOSING;
      src_net_nxt = 1'b0;
      esd_nxt     = 1'b0;
    end
  end

  // motion state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= VAC_IDLE;
      src_net_r <= 1'b0;
      esd_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      src_net_r <= src_net_nxt;
      esd_r     <= esd_nxt;
    end
  end

  // command history; a repeated cyclic word is not a new command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_cmd_r <= 16'h0000;
      blocked_r  <= 1'b0;
    end else begin
      if (out_strobe) last_cmd_r <= cmd;
      if (discard) blocked_r <= 1'b1;
      else if (accept) blocked_r <= 1'b0;
    end
  end

  // demand tracks every write in range, so the servo follows
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      demand_r <= `VAC_POS_ZERO;
    end else if (out_strobe && demand_ok) begin
      demand_r <= out_words.demand;
    end
  end

  // relays load only with the board fitted; reset de-energises
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay_r <= `VAC_RELAY_RST;
    end else if (out_strobe && cfg.relay_fitted) begin
      relay_r <= out_words.relay[`VAC_RELAY_BITS-1:0];
    end
  end

  // motor drive, registered so it never glitches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mo_r <= 1'b0;
      mc_r <= 1'b0;
    end else begin
      mo_r <= want_open  & ~p.ilk_open  & ~p.alarm;
      mc_r <= want_close & ~p.ilk_close & ~p.alarm;
    end
  end

  // status words; open/closed from limit switches, not torque
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r.flags                   <= '0;
      status_r.flags[`VAC_ST_OPEN]     <= p.lim_open;
      status_r.flags[`VAC_ST_CLOSED]   <= p.lim_close;
      status_r.flags[`VAC_ST_MOVING]   <= mo_r | mc_r;
      status_r.flags[`VAC_ST_POSMODE]  <= state_r == VAC_POSITION;
      status_r.flags[`VAC_ST_REMOTE]   <= p.remote;
      status_r.flags[`VAC_ST_ESD]      <= esd_r;
      status_r.flags[`VAC_ST_BLOCKED]  <= blocked_r;
      status_r.position                <= pos_feedback;
    end
  end

  // exchanged word sets follow the loaded configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_mask_r  <= 7'h00;
      out_mask_r <= 4'h0;
    end else begin
      in_mask_r  <= low_mask(cfg.in_words);
      out_mask_r <= out_mask_w[3:0];
    end
  end

  assign motor_open    = mo_r;
  assign motor_close   = mc_r;
  assign relay_out     = relay_r;
  assign status        = status_r;
  assign in_exch_mask  = in_mask_r;
  assign out_exch_mask = out_mask_r;
  assign pos_mode      = state_r == VAC_POSITION;
  assign esd_active    = esd_r;

  // checks on the command logic
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_OPEN_INTERLOCK: assert property (
    mo_r |-> $past(!p.ilk_open && !p.alarm))
    else $error("opening drive while open interlock active");

  AST_CLOSE_INTERLOCK: assert property (
    mc_r |-> $past(!p.ilk_close && !p.alarm))
    else $error("closing drive while close interlock active");

  AST_POS_REMOTE: assert property (
    $rose(state_r == VAC_POSITION) |-> $past(p.remote && !hw_any))
    else $error("positioning entered outside remote");

  AST_INHIBIT: assert property (
    (cmd_valid && inhibited) |=> (esd_r == $past(esd_r))
      && (state_r != VAC_POSITION || $past(state_r) == VAC_POSITION))
    else $error("inhibited command changed state");

  AST_MULTI_BIT: assert property (
    (out_strobe && $countones(cmd) > 1) |=> esd_r == $past(esd_r))
    else $error("multi-bit command word acted upon");

  AST_OPEN_LIMIT: assert property (
    (state_r == VAC_OPENING && open_done && !accept && !hw_go_open)
      |=> state_r != VAC_OPENING)
    else $error("opening did not stop at open limit");

  AST_CLOSE_LIMIT: assert property (
    (state_r == VAC_CLOSING && close_done && !accept && !hw_go_close)
      |=> state_r != VAC_CLOSING)
    else $error("closing did not stop at close limit");

  AST_STOP: assert property (
    (accept && cmd[`VAC_CMD_STOP] && !hw_go_open && !hw_go_close)
      |=> state_r == VAC_IDLE ##1 !mo_r && !mc_r)
    else $error("stop command did not halt motor");

  AST_ESD_CLOSE: assert property (
    (accept && is_esd && cfg.esd_action == `VAC_ESD_CLOSE
      && !hw_go_open && !hw_go_close) |=> state_r == VAC_CLOSING && esd_r)
    else $error("emergency close not taken");

  AST_STATUS_LIMIT: assert property (
    status_r.flags[`VAC_ST_OPEN] == $past(p.lim_open)
      && status_r.flags[`VAC_ST_CLOSED] == $past(p.lim_close))
    else $error("open or closed status not from limits");

  AST_POS_ENTER: assert property (
    (accept && cmd == `VAC_CMD_POS_WORD && !hw_go_open && !hw_go_close)
      |=> pos_mode)
    else $error("positioning not entered");

  AST_POS_EXIT: assert property (
    (pos_mode && accept && cmd != `VAC_CMD_POS_WORD
      && !hw_go_open && !hw_go_close) |=> !pos_mode)
    else $error("new command did not end positioning");

  AST_RELAY: assert property (
    (out_strobe && cfg.relay_fitted)
      |=> relay_out == $past(out_words.relay[3:0]))
    else $error("relay outputs did not follow relay word");

  AST_DEMAND_RANGE: assert property (
    demand_r <= `VAC_POS_FULL)
    else $error("demand beyond full travel");

endmodule : vac_cmd
`default_nettype wire

// *** bench/vac_master_model.sv ***
// network master model issuing cyclic output writes
`timescale 1ns/1ps
`default_nettype none
`include "vac_regs.svh"
module vac_master_model
  import vac_pkg::*;
(
  input  wire logic     clk_sys,
  output var  vac_out_words_t out_words,
  output var  logic     out_strobe
);
  // idle bus at reset, nothing strobed
  initial begin
    out_words = '0;
    out_strobe = 1'b0;
  end

  // one cyclic write, words valid only while strobed
  task automatic cyclic_write(input logic [15:0] w, input logic [15:0] d,
                              input logic [15:0] r);
    @(negedge clk_sys);
    out_words = {w, d, r};
    out_strobe = 1'b1;
    @(negedge clk_sys);
    out_strobe = 1'b0;
    // released words flip so stale data is never mistaken for fresh
    out_words = ~{w, d, r};
  endtask : cyclic_write

  // position request: only the position-enable bit plus a demand
  task automatic start_positioning(input logic [15:0] d,
                                   input logic [15:0] r);
    cyclic_write(`VAC_CMD_POS_WORD, d, r);
  endtask : start_positioning
endmodule : vac_master_model
`default_nettype wire

// *** bench/valve_actuator_command_logic_tb_top.sv ***
// self-checking bench for the valve actuator command logic
`timescale 1ns/1ps
`default_nettype none
module valve_actuator_command_logic_tb_top
  import vac_pkg::*;
();
  logic           clk_sys;
  logic           rst_n;
  vac_out_words_t out_words;
  logic           out_strobe;
  vac_cfg_t       cfg;
  vac_pins_t      pins_async;
  logic [15:0]    pos_feedback;
  logic           motor_open;
  logic           motor_close;
  logic [3:0]     relay_out;
  vac_status_t    status;
  logic [6:0]     in_exch_mask;
  logic [3:0]     out_exch_mask;
  logic           pos_mode;
  logic           esd_active;
  logic [15:0]    relay_w;
  int             mismatches;
  int             cmp_count;

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  vac_master_model master (.clk_sys(clk_sys), .out_words(out_words),
                           .out_strobe(out_strobe));

  vac_cmd dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .out_words(out_words),
    .out_strobe(out_strobe), .cfg(cfg), .pins_async(pins_async),
    .pos_feedback(pos_feedback), .motor_open(motor_open),
    .motor_close(motor_close), .relay_out(relay_out), .status(status),
    .in_exch_mask(in_exch_mask), .out_exch_mask(out_exch_mask),
    .pos_mode(pos_mode), .esd_active(esd_active)
  );

  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : hold

  // motor pair compared as one value
  task automatic motors(input logic o, input logic c);
    check("motors", {14'h0, motor_open, motor_close}, {14'h0, o, c});
  endtask : motors

  // command write, then wait out the two-edge answer
  task automatic cmd(input logic [15:0] w, input logic [15:0] d = 16'h0);
    master.cyclic_write(w, d, relay_w);
    hold(2);
  endtask : cmd

  task automatic pos(input logic [15:0] d);
    master.start_positioning(d, relay_w);
    hold(2);
  endtask : pos

  // sync chain needs about four edges, six is margin
  task automatic pins_to(input vac_pins_t p);
    pins_async = p;
    hold(6);
  endtask : pins_to

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end

  vac_pins_t base;
  vac_pins_t gate_p;

  initial begin
    rst_n = 1'b0;
    cfg = '0;
    cfg.inhibit_en = 1'b1;
    cfg.relay_fitted = 1'b1;
    cfg.deadband = 10'h005;
    cfg.in_words = 3'h7;
    cfg.out_words = 2'h3;
    base = '0;
    base.remote = 1'b1;
    pins_async = base;
    pos_feedback = 16'h01F4;
    relay_w = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    hold(10);
    motors(0, 0);
    check("relay_rst", {12'h0, relay_out}, 16'h0000);
    rst_n = 1'b1;
    hold(6);
    check("in_mask", {9'h0, in_exch_mask}, 16'h007F);
    check("out_mask", {12'h0, out_exch_mask}, 16'h000F);
    cfg.in_words = 3'h2;
    cfg.out_words = 2'h1;
    hold(2);
    check("in_mask", {9'h0, in_exch_mask}, 16'h0003);
    check("out_mask", {12'h0, out_exch_mask}, 16'h0003);
    // open runs to the open limit
    cmd(16'h0004);
    motors(1, 0);
    pins_to('{remote: 1'b1, lim_open: 1'b1, default: 1'b0});
    motors(0, 0);
    check("limits", {14'h0, status.flags[1:0]}, 16'h0001);
    // torque away from a limit neither stops nor reports closed
    cmd(16'h0002);
    motors(0, 1);
    pins_to('{remote: 1'b1, torque_trip: 1'b1, default: 1'b0});
    motors(0, 1);
    check("limits", {14'h0, status.flags[1:0]}, 16'h0000);
    cmd(16'h0001);
    motors(0, 0);
    pins_to(base);
    // a new command replaces a running one back to back
    cmd(16'h0004);
    cmd(16'h0002);
    motors(0, 1);
    cmd(16'h0006);
    motors(0, 1);
    // a malformed word is dropped silently, no blocked flag
    check("discard", {15'h0, status.flags[6]}, 16'h0000);
    cmd(16'h0041);
    motors(0, 1);
    cmd(16'h0001);
    motors(0, 0);
    // each gating condition discards an open request
    for (int i = 0; i < 5; i++) begin
      gate_p = base;
      case (i)
        0: gate_p.remote = 1'b0;
        1: gate_p.inhibit = 1'b1;
        2: gate_p.ilk_open = 1'b1;
        3: gate_p.alarm = 1'b1;
        default: gate_p.hw_close = 1'b1;
      endcase
      pins_to(gate_p);
      cmd(16'h0000);
      cmd(16'h0004);
      motors(0, i == 4);
      check("discard", {15'h0, status.flags[6]}, 16'h0001);
      pins_to(base);
    end
    // open interlock halts opening already under way; the loop left 0004
    // as the last word, so a different word goes first
    cmd(16'h0000);
    cmd(16'h0004);
    motors(1, 0);
    pins_to('{remote: 1'b1, ilk_open: 1'b1, default: 1'b0});
    motors(0, 0);
    pins_to(base);
    cmd(16'h0001);
    // emergency action per setting; works out of remote too
    for (int k = 0; k < 3; k++) begin
      cfg.esd_action = k[1:0];
      if (k == 1) pins_to('{default: 1'b0});
      cmd(16'h0008);
      motors(k == 1, k == 0);
      check("esd", {14'h0, esd_active, status.flags[5]}, 16'h0003);
      pins_to(base);
      cmd(16'h0001);
      check("esd", {14'h0, esd_active, status.flags[5]}, 16'h0000);
    end
    // analogue positioning around the deadband
    pos(16'h0258);
    check("pos_mode", {14'h0, pos_mode, status.flags[3]}, 16'h0003);
    motors(1, 0);
    pos_feedback = 16'h0256;
    hold(3);
    motors(0, 0);
    check("pos_mode", {15'h0, pos_mode}, 16'h0001);
    pos(16'h0190);
    hold(1);
    motors(0, 1);
    pos(16'h03E9);
    hold(1);
    motors(0, 1);
    pos_feedback = 16'h0000;
    pos(16'h0000);
    hold(1);
    motors(0, 1);
    pos_feedback = 16'h03E8;
    pos(16'h03E8);
    hold(1);
    motors(1, 0);
    cfg.limited_range = 1'b1;
    hold(3);
    motors(0, 0);
    cfg.limited_range = 1'b0;
    cmd(16'h0002);
    motors(0, 1);
    check("pos_mode", {15'h0, pos_mode}, 16'h0000);
    cmd(16'h0001);
    check("position", status.position, pos_feedback);
    // relays follow bits 3:0 only while the board is fitted
    relay_w = 16'hFFFA;
    cmd(16'h0000);
    check("relays", {12'h0, relay_out}, 16'h000A);
    cfg.relay_fitted = 1'b0;
    relay_w = 16'h0005;
    cmd(16'h0000);
    check("relays", {12'h0, relay_out}, 16'h000A);
    test_done();
  end
endmodule : valve_actuator_command_logic_tb_top
`default_nettype wire
